// ===== msd_pkg.sv
// constants, types and helper functions of the memory space address decoder
// assumes a single system clock and an active-low asynchronous reset
package msd_pkg;

  // ==========================================================================
  // widths and target indices
  localparam int ADDR_W   = 16;
  localparam int DATA_W   = 8;
  localparam int TGT_N    = 6;
  localparam int T_FLASH  = 0;
  localparam int T_XRAM   = 1;
  localparam int T_XPER   = 2;
  localparam int T_IRAM   = 3;
  localparam int T_SFR    = 4;
  localparam int T_NONE   = 5;

  // ==========================================================================
  // address map
  localparam logic [15:0] FLASH_LO     = 16'h0000;
  localparam logic [15:0] FLASH_HI     = 16'h7FFF;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] XRAM_LO      = 16'h0000;
  localparam logic [15:0] XRAM_HI      = 16'h02FF;
  localparam logic [15:0] XPER_LO      = 16'h4018;
  localparam logic [15:0] XPER_HI      = 16'h40FF;
  localparam logic [15:0] XADC_LO      = 16'h0600;
  localparam logic [15:0] XADC_HI      = 16'h061F;
  localparam logic [7:0]  BANK_HI      = 8'h1F;
  localparam logic [7:0]  BITRAM_BASE  = 8'h20;
  localparam logic [7:0]  BITRAM_HI    = 8'h2F;
  localparam logic [7:0]  LOWRAM_HI    = 8'h7F;
  localparam logic [7:0]  UPPER_LO     = 8'h80;
  localparam logic [3:0]  SFR_NIB_A    = 4'h0;
  localparam logic [3:0]  SFR_NIB_B    = 4'h8;
  localparam logic [7:0]  NONE_RDATA   = 8'hFF;
  localparam logic [15:0] ZERO_ADDR    = 16'h0000;
  localparam logic [7:0]  ZERO_DATA    = 8'h00;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    KIND_FETCH, KIND_DIRECT, KIND_INDIRECT, KIND_MOVX, KIND_BIT, KIND_WREG, KIND_STACK
  } msd_kind_t;

  typedef enum logic {ST_BOOT, ST_RUN} msd_state_t;

  // ==========================================================================
  // helpers
  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [7:0] bit_to_byte(input logic [7:0] b);
    return b[7] ? {b[7:3], 3'h0} : 8'(BITRAM_BASE + {4'h0, b[6:3]});
  endfunction

  function automatic logic sfr_bit_ok(input logic [7:0] a);
    return (a[3:0] == SFR_NIB_A) || (a[3:0] == SFR_NIB_B);
  endfunction

endpackage

// ===== msd_dec_if.sv
// carries one access between the decoder core and its address classifier
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
interface msd_dec_if;
  import msd_pkg::*;
  msd_kind_t         kind;
  logic [15:0]       addr;
  logic [1:0]        bank;
  logic [TGT_N-1:0]  sel;
  logic [15:0]       tgt_addr;
  logic [2:0]        tgt_bit;

  modport req (output kind, output addr, output bank, input sel, input tgt_addr, input tgt_bit);
  modport dec (input kind, input addr, input bank, output sel, output tgt_addr, output tgt_bit);
endinterface

// ===== msd_classify.sv
// pure address classifier: kind plus address to one-hot target and local address
// assumes inputs are stable for the cycle in which they are sampled
`timescale 1ns/1ps
module msd_classify (
  msd_dec_if.dec d
);
  import msd_pkg::*;

  // ==========================================================================
  // classification
  always_comb begin
    d.sel      = '0;
    d.tgt_addr = d.addr;
    d.tgt_bit  = 3'h0;
    case (d.kind)
      KIND_FETCH: begin
        if (in_rng(d.addr, FLASH_LO, FLASH_HI)) d.sel[T_FLASH] = 1'b1;
        else d.sel[T_NONE] = 1'b1;
      end
      KIND_MOVX: begin
        if (in_rng(d.addr, XRAM_LO, XRAM_HI)) d.sel[T_XRAM] = 1'b1;
        else if (in_rng(d.addr, XPER_LO, XPER_HI) || in_rng(d.addr, XADC_LO, XADC_HI)) d.sel[T_XPER] = 1'b1;
        else d.sel[T_NONE] = 1'b1;
      end
      KIND_DIRECT: begin
        d.tgt_addr = {8'h00, d.addr[7:0]};
        if (d.addr[7:0] >= UPPER_LO) d.sel[T_SFR] = 1'b1;
        else d.sel[T_IRAM] = 1'b1;
      end
      KIND_INDIRECT, KIND_STACK: begin
        d.tgt_addr = {8'h00, d.addr[7:0]};
        d.sel[T_IRAM] = 1'b1;
      end
      KIND_WREG: begin
        d.tgt_addr = {11'h000, d.bank, d.addr[2:0]};
        d.sel[T_IRAM] = 1'b1;
      end
      KIND_BIT: begin
        d.tgt_addr = {8'h00, bit_to_byte(d.addr[7:0])};
        d.tgt_bit  = d.addr[2:0];
        if (d.addr[7] && sfr_bit_ok(bit_to_byte(d.addr[7:0]))) d.sel[T_SFR] = 1'b1;
        else if (!d.addr[7]) d.sel[T_IRAM] = 1'b1;
        else d.sel[T_NONE] = 1'b1;
      end
      default: d.sel[T_NONE] = 1'b1;
    endcase
  end
endmodule

// ===== msd_decoder.sv
// memory space address decoder: routes each core access to one storage target
// assumes the core holds a request until REQ_READY is high; targets answer reads in the select cycle
//
// Notes on behaviour
// - program and data spaces decoded separately
// - fetches 0x0000 to 0x7FFF reach flash
// - first fetch after reset is 0x0000
// - external 0x0000 to 0x02FF is external RAM
// - 0x00-0x1F: four banks, eight registers
// - 0x20-0x2F also bit addressable
// - 0x30-0x7F direct and indirect RAM
// - indirect 0x80-0xFF reaches upper RAM
// - direct 0x80-0xFF reaches special registers
// - stack accesses go to internal RAM
// - special register bits only at nibble 0/8
// - extended peripheral space inside external space
`timescale 1ns/1ps
module msd_decoder (
  // clock and reset
  input  wire logic                      CLK,
  input  wire logic                      NRST,
  // core request
  input  wire logic                      REQ_VALID,
  input  wire msd_pkg::msd_kind_t        REQ_KIND,
  input  wire logic [15:0]               REQ_ADDR,
  input  wire logic                      REQ_WR,
  input  wire logic [7:0]                REQ_WDATA,
  input  wire logic [1:0]                BANK_SEL,
  output logic                           REQ_READY,
  // target side
  output logic [msd_pkg::TGT_N-1:0]      TGT_SEL,
  output logic [15:0]                    TGT_ADDR,
  output logic [2:0]                     TGT_BIT,
  output logic                           TGT_WR,
  output logic [7:0]                     TGT_WDATA,
  input  wire logic [7:0]                FLASH_RDATA,
  input  wire logic [7:0]                XRAM_RDATA,
  input  wire logic [7:0]                XPER_RDATA,
  input  wire logic [7:0]                IRAM_RDATA,
  input  wire logic [7:0]                SFR_RDATA,
  // read answer and access fault
  output logic [7:0]                     RD_DATA,
  output logic                           RD_VALID,
  output logic                           ACC_FAULT
);
  import msd_pkg::*;

  // ==========================================================================
  // classifier
  msd_dec_if dif ();
  msd_classify u_classify (
    .d (dif)
  );

  msd_state_t        state_reg, state_next;
  logic              ready_reg, ready_next;
  logic [TGT_N-1:0]  sel_reg,   sel_next;
  logic [15:0]       addr_reg,  addr_next;
  logic [2:0]        bit_reg,   bit_next;
  logic              wr_reg,    wr_next;
  logic [7:0]        wdata_reg, wdata_next;
  logic [7:0]        rdata_reg, rdata_next;
  logic              rvld_reg,  rvld_next;
  logic              fault_reg, fault_next;
  logic              take;
  logic [7:0]        mux_data;

  assign take     = REQ_VALID && ready_reg;
  assign dif.kind = REQ_KIND;
  assign dif.addr = REQ_ADDR;
  assign dif.bank = BANK_SEL;

  // ==========================================================================
  // read return path
  always_comb begin
    mux_data = NONE_RDATA;
    case (1'b1)
      sel_reg[T_FLASH]: mux_data = FLASH_RDATA;
      sel_reg[T_XRAM]:  mux_data = XRAM_RDATA;
      sel_reg[T_XPER]:  mux_data = XPER_RDATA;
      sel_reg[T_IRAM]:  mux_data = IRAM_RDATA;
      sel_reg[T_SFR]:   mux_data = SFR_RDATA;
      default:          mux_data = NONE_RDATA;
    endcase
  end

  // ==========================================================================
  // next state
  always_comb begin
    state_next = state_reg;
    ready_next = ready_reg;
    sel_next   = '0;
    addr_next  = addr_reg;
    bit_next   = bit_reg;
    wr_next    = 1'b0;
    wdata_next = wdata_reg;
    rvld_next  = 1'b0;
    rdata_next = rdata_reg;
    fault_next = 1'b0;
    if (|sel_reg && !wr_reg) begin
      rvld_next  = 1'b1;
      rdata_next = mux_data;
    end
    case (state_reg)
      ST_BOOT: begin
        sel_next[T_FLASH] = 1'b1;
        addr_next  = RESET_VECTOR;
        bit_next   = 3'h0;
        state_next = ST_RUN;
        ready_next = 1'b1;
      end
      ST_RUN: begin
        if (take) begin
          sel_next   = dif.sel;
          addr_next  = dif.tgt_addr;
          bit_next   = dif.tgt_bit;
          wr_next    = REQ_WR && (REQ_KIND != KIND_FETCH);
          wdata_next = REQ_WDATA;
          fault_next = dif.sel[T_NONE];
        end
      end
      default: begin
        state_next = ST_BOOT;
        ready_next = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // registers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= ST_BOOT;
      ready_reg <= 1'b0;
      sel_reg   <= '0;
      addr_reg  <= ZERO_ADDR;
      bit_reg   <= 3'h0;
      wr_reg    <= 1'b0;
      wdata_reg <= ZERO_DATA;
      rdata_reg <= ZERO_DATA;
      rvld_reg  <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= ready_next;
      sel_reg   <= sel_next;
      addr_reg  <= addr_next;
      bit_reg   <= bit_next;
      wr_reg    <= wr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      rvld_reg  <= rvld_next;
      fault_reg <= fault_next;
    end
  end

  assign REQ_READY = ready_reg;
  assign TGT_SEL   = sel_reg;
  assign TGT_ADDR  = addr_reg;
  assign TGT_BIT   = bit_reg;
  assign TGT_WR    = wr_reg;
  assign TGT_WDATA = wdata_reg;
  assign RD_DATA   = rdata_reg;
  assign RD_VALID  = rvld_reg;
  assign ACC_FAULT = fault_reg;

  // ==========================================================================
  // checks
  chk_sel_onehot: assert property (@(posedge CLK) disable iff (!NRST)
    $onehot0(TGT_SEL))
    else $error("more than one target selected");

  chk_take_one_sel: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY |=> $onehot(TGT_SEL))
    else $error("accepted access selected no single target");

  chk_boot_fetch: assert property (@(posedge CLK) disable iff (!NRST)
    $rose(REQ_READY) |-> TGT_SEL[T_FLASH] && TGT_ADDR == RESET_VECTOR && $past(state_reg) == ST_BOOT)
    else $error("first fetch after reset not at reset vector");

  chk_fetch_flash: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && REQ_KIND == KIND_FETCH && REQ_ADDR <= FLASH_HI
    |=> TGT_SEL[T_FLASH] && TGT_ADDR == $past(REQ_ADDR))
    else $error("program fetch not routed to flash");

  chk_data_not_flash: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && REQ_KIND != KIND_FETCH |=> !TGT_SEL[T_FLASH])
    else $error("data access reached program memory");

  chk_movx_xram: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && REQ_KIND == KIND_MOVX && REQ_ADDR <= XRAM_HI |=> TGT_SEL[T_XRAM])
    else $error("external move not routed to external RAM");

  chk_xspace_movx: assert property (@(posedge CLK) disable iff (!NRST)
    (TGT_SEL[T_XRAM] || TGT_SEL[T_XPER]) |-> $past(REQ_KIND) == KIND_MOVX)
    else $error("external space reached without external move");

  chk_xper_map: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && REQ_KIND == KIND_MOVX && in_rng(REQ_ADDR, XPER_LO, XPER_HI)
    |=> TGT_SEL[T_XPER] && TGT_ADDR == $past(REQ_ADDR))
    else $error("extended peripheral access misrouted");

  chk_wreg_bank: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && REQ_KIND == KIND_WREG
    |=> TGT_SEL[T_IRAM] && TGT_ADDR[7:0] == {3'h0, $past(BANK_SEL), $past(REQ_ADDR[2:0])})
    else $error("working register not in active bank");

  chk_bit_ram: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && REQ_KIND == KIND_BIT && !REQ_ADDR[7]
    |=> TGT_SEL[T_IRAM] && TGT_ADDR[7:0] >= BITRAM_BASE && TGT_ADDR[7:0] <= BITRAM_HI)
    else $error("bit address outside bit area");

  chk_direct_low: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && REQ_KIND == KIND_DIRECT && REQ_ADDR[7:0] <= LOWRAM_HI |=> TGT_SEL[T_IRAM])
    else $error("direct low address not in RAM");

  chk_indirect_up: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && REQ_KIND == KIND_INDIRECT && REQ_ADDR[7] |=> TGT_SEL[T_IRAM])
    else $error("indirect upper access not in RAM");

  chk_direct_up: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && REQ_KIND == KIND_DIRECT && REQ_ADDR[7] |=> TGT_SEL[T_SFR])
    else $error("direct upper access not in special registers");

  chk_stack_iram: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && REQ_KIND == KIND_STACK |=> TGT_SEL[T_IRAM])
    else $error("stack access left internal RAM");

  chk_sfr_bit_nib: assert property (@(posedge CLK) disable iff (!NRST)
    TGT_SEL[T_SFR] && $past(REQ_KIND) == KIND_BIT |-> sfr_bit_ok(TGT_ADDR[7:0]))
    else $error("bit access to non bit-addressable register");

  chk_read_return: assert property (@(posedge CLK) disable iff (!NRST)
    TGT_SEL[T_IRAM] && !TGT_WR |=> RD_VALID && RD_DATA == $past(IRAM_RDATA))
    else $error("read data not returned from selected target");

  chk_fault_pulse: assert property (@(posedge CLK) disable iff (!NRST)
    ACC_FAULT == TGT_SEL[T_NONE])
    else $error("fault pulse not aligned with unmapped select");

  chk_none_rdata: assert property (@(posedge CLK) disable iff (!NRST)
    TGT_SEL[T_NONE] && !TGT_WR |=> RD_VALID && RD_DATA == NONE_RDATA)
    else $error("unmapped read did not return filler data");

  chk_fetch_no_write: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && REQ_KIND == KIND_FETCH |=> !TGT_WR)
    else $error("program fetch raised a write strobe");

  chk_write_no_read: assert property (@(posedge CLK) disable iff (!NRST)
    TGT_WR |=> !RD_VALID)
    else $error("write access returned read data");

  chk_idle_no_sel: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_READY && !REQ_VALID |=> TGT_SEL == '0)
    else $error("target selected without a request");

  chk_read_after_sel: assert property (@(posedge CLK) disable iff (!NRST)
    RD_VALID |-> $past(TGT_SEL) != '0 && !$past(TGT_WR))
    else $error("read answer without a read select");

  chk_data_not_ext: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && REQ_KIND != KIND_MOVX |=> !TGT_SEL[T_XRAM] && !TGT_SEL[T_XPER])
    else $error("non external move reached external space");

  chk_int_addr_byte: assert property (@(posedge CLK) disable iff (!NRST)
    (TGT_SEL[T_IRAM] || TGT_SEL[T_SFR]) |-> TGT_ADDR[15:8] == 8'h00)
    else $error("internal target address wider than a byte");

  chk_indirect_addr: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && REQ_KIND == KIND_INDIRECT |=> TGT_ADDR[7:0] == $past(REQ_ADDR[7:0]))
    else $error("indirect address not passed through");

  chk_direct_addr: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && REQ_KIND == KIND_DIRECT |=> TGT_ADDR[7:0] == $past(REQ_ADDR[7:0]))
    else $error("direct address not passed through");

  chk_bit_number: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && REQ_KIND == KIND_BIT |=> TGT_BIT == $past(REQ_ADDR[2:0]))
    else $error("bit number not taken from bit address");

  chk_bit_sfr_byte: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && REQ_KIND == KIND_BIT && REQ_ADDR[7]
    |=> TGT_SEL[T_SFR] && TGT_ADDR[7:3] == $past(REQ_ADDR[7:3]) && TGT_ADDR[2:0] == 3'h0)
    else $error("upper bit address not at register base");

  chk_stack_addr: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && REQ_KIND == KIND_STACK |=> TGT_ADDR[7:0] == $past(REQ_ADDR[7:0]))
    else $error("stack address not passed through");

  chk_write_data: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && REQ_WR && REQ_KIND != KIND_FETCH |=> TGT_WR && TGT_WDATA == $past(REQ_WDATA))
    else $error("write data not passed to target");

  chk_flash_read: assert property (@(posedge CLK) disable iff (!NRST)
    TGT_SEL[T_FLASH] |=> RD_VALID && RD_DATA == $past(FLASH_RDATA))
    else $error("flash data not returned on read path");

  chk_sfr_read: assert property (@(posedge CLK) disable iff (!NRST)
    TGT_SEL[T_SFR] && !TGT_WR |=> RD_VALID && RD_DATA == $past(SFR_RDATA))
    else $error("special register data not returned on read path");

endmodule

// ===== msd_core_model.sv
// core model: issues one access at a time on the decoder request port
// assumes drive and idle are called just after a falling edge of clk
`timescale 1ns/1ps
module msd_core_model (
  // clock and handshake
  input  wire logic        clk,
  input  wire logic        req_ready,
  // request
  output logic             req_valid,
  output msd_pkg::msd_kind_t req_kind,
  output logic [15:0]      req_addr,
  output logic             req_wr,
  output logic [7:0]       req_wdata,
  output logic [1:0]       bank_sel
);
  import msd_pkg::*;

  // ==========================================================================
  // request driver
  initial begin
    req_valid = 1'b0;
    req_kind  = KIND_FETCH;
    req_addr  = 16'h0000;
    req_wr    = 1'b0;
    req_wdata = 8'h00;
    bank_sel  = 2'h0;
  end

  // hold everything until the edge that sees ready high
  task automatic drive(input msd_kind_t k, input logic [15:0] a, input logic w, input logic [7:0] d,
                       input logic [1:0] b);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_kind  = k; // external space only with the movx kind
    req_addr  = a;
    req_wr    = w;
    req_wdata = d;
    bank_sel  = b;
    @(posedge clk);
    while (req_ready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
  endtask

  // valid drops; address and write data lines show the inverse of their last value, other lines keep theirs
  task automatic idle;
    req_valid = 1'b0;
    req_addr  = ~req_addr;
    req_wdata = ~req_wdata;
  endtask
endmodule

// ===== memory_space_address_decoder_bench.sv
// bench for the memory space address decoder, core model on the request side
// assumes target read data answers from the registered target address
`timescale 1ns/1ps
module memory_space_address_decoder_bench;
  import msd_pkg::*;

  // ==========================================================================
  // signals
  logic              clk, nrst, req_valid, req_ready, req_wr, tgt_wr, rd_valid, acc_fault;
  msd_kind_t         req_kind;
  logic [15:0]       req_addr, tgt_addr;
  logic [7:0]        req_wdata, tgt_wdata, rd_data, rd_flash, rd_xram, rd_xper, rd_iram, rd_sfr;
  logic [1:0]        bank_sel;
  logic [2:0]        tgt_bit;
  logic [TGT_N-1:0]  tgt_sel;
  int                err_count = 0;
  int                checked = 0;
  int                cycles = 0;

  // ==========================================================================
  // targets answer with their local address under a per-target key
  assign rd_flash = tgt_addr[7:0] ^ 8'hA5;
  assign rd_xram  = tgt_addr[7:0] ^ 8'h3C;
  assign rd_xper  = tgt_addr[7:0] ^ 8'hC3;
  assign rd_iram  = tgt_addr[7:0] ^ 8'h69;
  assign rd_sfr   = tgt_addr[7:0] ^ 8'h96;

  msd_core_model core (.clk(clk), .req_ready(req_ready), .req_valid(req_valid), .req_kind(req_kind),
    .req_addr(req_addr), .req_wr(req_wr), .req_wdata(req_wdata), .bank_sel(bank_sel));

  msd_decoder i_dut (.CLK(clk), .NRST(nrst), .REQ_VALID(req_valid), .REQ_KIND(req_kind),
    .REQ_ADDR(req_addr), .REQ_WR(req_wr), .REQ_WDATA(req_wdata), .BANK_SEL(bank_sel),
    .REQ_READY(req_ready), .TGT_SEL(tgt_sel), .TGT_ADDR(tgt_addr), .TGT_BIT(tgt_bit), .TGT_WR(tgt_wr),
    .TGT_WDATA(tgt_wdata), .FLASH_RDATA(rd_flash), .XRAM_RDATA(rd_xram), .XPER_RDATA(rd_xper),
    .IRAM_RDATA(rd_iram), .SFR_RDATA(rd_sfr), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .ACC_FAULT(acc_fault));

  // ==========================================================================
  // clock, timeout and checking helpers
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic compare(input string what, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] rd_exp(input int ti, input logic [15:0] ta);
    case (ti)
      T_FLASH: return ta[7:0] ^ 8'hA5;
      T_XRAM:  return ta[7:0] ^ 8'h3C;
      T_XPER:  return ta[7:0] ^ 8'hC3;
      T_IRAM:  return ta[7:0] ^ 8'h69;
      T_SFR:   return ta[7:0] ^ 8'h96;
      default: return 8'hFF;
    endcase
  endfunction

  // one access, then its select cycle, then its answer cycle
  task automatic xfer(input msd_kind_t k, input logic [15:0] a, input logic w, input logic [1:0] b,
                      input int ti, input logic [15:0] ta, input logic [2:0] tb);
    @(negedge clk);
    core.drive(k, a, w, a[7:0] ^ 8'h1E, b);
    @(negedge clk);
    core.idle();
    compare("target select", 16'(tgt_sel), 16'(1) << ti);
    if (ti != T_NONE) compare("target address", tgt_addr, ta);
    compare("bit number", 16'(tgt_bit), 16'(tb));
    compare("write strobe", 16'(tgt_wr), 16'(w));
    if (w) compare("write data", 16'(tgt_wdata), 16'(a[7:0] ^ 8'h1E));
    compare("fault", 16'(acc_fault), 16'(ti == T_NONE));
    @(negedge clk);
    compare("read valid", 16'(rd_valid), 16'(!w));
    if (!w) compare("read data", 16'(rd_data), 16'(rd_exp(ti, ta)));
    compare("idle select", 16'(tgt_sel), 16'h0000);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    @(negedge clk);
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    compare("boot select", 16'(tgt_sel), 16'h0001);
    compare("boot address", tgt_addr, 16'h0000);
    compare("ready", 16'(req_ready), 16'h0001);
    @(negedge clk);
    compare("boot data", 16'(rd_data), 16'h00A5);
    compare("boot valid", 16'(rd_valid), 16'h0001);
    $display("test reset done");
  endtask

  task automatic t_prog;
    xfer(KIND_FETCH, 16'h0000, 1'b0, 2'h0, T_FLASH, 16'h0000, 3'h0);
    xfer(KIND_FETCH, 16'h7FFF, 1'b0, 2'h0, T_FLASH, 16'h7FFF, 3'h0);
    xfer(KIND_FETCH, 16'h8000, 1'b0, 2'h0, T_NONE, 16'h0000, 3'h0);
    xfer(KIND_FETCH, 16'h0100, 1'b0, 2'h0, T_FLASH, 16'h0100, 3'h0);
    xfer(KIND_MOVX, 16'h0100, 1'b0, 2'h0, T_XRAM, 16'h0100, 3'h0);
    $display("test program space done");
  endtask

  task automatic t_xdata;
    logic [15:0] xa[6] = '{16'h4018, 16'h40FF, 16'h0600, 16'h061F, 16'h4017, 16'h0620};
    xfer(KIND_MOVX, 16'h0000, 1'b0, 2'h0, T_XRAM, 16'h0000, 3'h0);
    xfer(KIND_MOVX, 16'h02FF, 1'b0, 2'h0, T_XRAM, 16'h02FF, 3'h0);
    xfer(KIND_MOVX, 16'h0300, 1'b0, 2'h0, T_NONE, 16'h0300, 3'h0);
    xfer(KIND_MOVX, 16'h0155, 1'b1, 2'h0, T_XRAM, 16'h0155, 3'h0);
    xfer(KIND_DIRECT, 16'h0100, 1'b0, 2'h0, T_IRAM, 16'h0000, 3'h0);
    xfer(KIND_INDIRECT, 16'h02FF, 1'b0, 2'h0, T_IRAM, 16'h00FF, 3'h0);
    foreach (xa[i]) xfer(KIND_MOVX, xa[i], 1'b0, 2'h0, (i < 4) ? T_XPER : T_NONE, xa[i], 3'h0);
    $display("test external space done");
  endtask

  task automatic t_internal;
    for (int b = 0; b < 4; b++) begin
      xfer(KIND_WREG, 16'h0007, 1'b0, 2'(b), T_IRAM, {11'h0, 2'(b), 3'h7}, 3'h0);
      xfer(KIND_WREG, 16'h0000, 1'b1, 2'(b), T_IRAM, {11'h0, 2'(b), 3'h0}, 3'h0);
    end
    xfer(KIND_BIT, 16'h0000, 1'b0, 2'h0, T_IRAM, 16'h0020, 3'h0);
    xfer(KIND_BIT, 16'h007F, 1'b0, 2'h0, T_IRAM, 16'h002F, 3'h7);
    xfer(KIND_DIRECT, 16'h002A, 1'b0, 2'h0, T_IRAM, 16'h002A, 3'h0);
    xfer(KIND_BIT, 16'h0080, 1'b0, 2'h0, T_SFR, 16'h0080, 3'h0);
    xfer(KIND_BIT, 16'h00FF, 1'b0, 2'h0, T_SFR, 16'h00F8, 3'h7);
    xfer(KIND_BIT, 16'h008B, 1'b1, 2'h0, T_SFR, 16'h0088, 3'h3);
    xfer(KIND_DIRECT, 16'h0030, 1'b0, 2'h0, T_IRAM, 16'h0030, 3'h0);
    xfer(KIND_INDIRECT, 16'h007F, 1'b0, 2'h0, T_IRAM, 16'h007F, 3'h0);
    xfer(KIND_INDIRECT, 16'h0080, 1'b0, 2'h0, T_IRAM, 16'h0080, 3'h0);
    xfer(KIND_INDIRECT, 16'h00FF, 1'b1, 2'h0, T_IRAM, 16'h00FF, 3'h0);
    xfer(KIND_DIRECT, 16'h0080, 1'b0, 2'h0, T_SFR, 16'h0080, 3'h0);
    xfer(KIND_DIRECT, 16'h00FF, 1'b0, 2'h0, T_SFR, 16'h00FF, 3'h0);
    xfer(KIND_STACK, 16'h00C1, 1'b1, 2'h0, T_IRAM, 16'h00C1, 3'h0);
    $display("test internal space done");
  endtask

  task automatic t_b2b;
    @(negedge clk);
    core.drive(KIND_DIRECT, 16'h0081, 1'b0, 8'h00, 2'h0);
    @(negedge clk);
    compare("first select", 16'(tgt_sel), 16'(1) << T_SFR);
    core.drive(KIND_INDIRECT, 16'h0081, 1'b0, 8'h00, 2'h0);
    @(negedge clk);
    core.idle();
    compare("first data", 16'(rd_data), 16'(8'h81 ^ 8'h96));
    compare("second select", 16'(tgt_sel), 16'(1) << T_IRAM);
    @(negedge clk);
    compare("second data", 16'(rd_data), 16'(8'h81 ^ 8'h69));
    $display("test back to back done");
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    t_reset();
    t_prog();
    t_xdata();
    t_internal();
    t_b2b();
    t_reset();
    t_b2b();
    wrap_up();
  end
endmodule
